// file: logic/ppm_port_mux.v
// pin function multiplexer for an 8-pin port and a 6-pin port with edge interrupt flags
// assumes pins synchronised here; module signals on core_clk
`timescale 1ns/1ps
`include "ppm_consts.vh"
module ppm_port_mux (
    input wire core_clk,
    input wire reset_n,
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    input wire [2:0] lcd_port_range_field,
    input wire [3:0] supervisor_level_field,
    input wire [7:0] port1_pin_in,
    output wire [7:0] port1_pin_out,
    output wire [7:0] port1_pin_oe,
    output wire [7:0] port1_lcd_mode,
    input wire [5:0] port2_pin_in,
    output wire [5:0] port2_pin_out,
    output wire [5:0] port2_pin_oe,
    output wire [5:0] port2_lcd_mode,
    input wire timer_out1,
    input wire timer_out2,
    input wire supervisor_output,
    input wire aux_clock,
    input wire serial_simo_out,
    input wire serial_somi_out,
    input wire serial_clock_out,
    input wire serial_transmit_data,
    input wire dir_ctrl_data_out_line,
    input wire dir_ctrl_data_in_line,
    input wire dir_ctrl_serial_clock,
    output wire timer_capture_in_1a,
    output wire timer_capture_in_2a,
    output wire timer_external_clock,
    output wire serial_slave_in_master_out,
    output wire serial_slave_out_master_in,
    output wire serial_clock_line,
    output wire serial_slave_strobe,
    output wire serial_receive_data,
    output wire port1_irq,
    output wire port2_irq
);
    reg [7:0] port1_output_q, port1_direction_q, port1_irq_flag_q;
    reg [7:0] port1_edge_select_q, port1_irq_enable_q, port1_function_select_q;
    reg [7:0] port2_output_q, port2_direction_q, port2_irq_flag_q;
    reg [7:0] port2_edge_select_q, port2_irq_enable_q, port2_function_select_q;
    reg [7:0] p1_meta_q, p1_sync_q, p1_prev_q;
    reg [7:0] p2_meta_q, p2_sync_q, p2_prev_q;
    wire [7:0] port1_input;
    wire [7:0] port2_input;
    wire [7:0] p1_edge;
    wire [7:0] p2_edge;
    wire [7:0] p1_mod_out;
    wire [7:0] p2_mod_out;
    wire [7:0] p1_mod_oe;
    wire [7:0] p2_mod_oe;
    wire [7:0] p1_pad_in;
    wire [7:0] p2_pad_in;
    wire p2_3_buffer_off;
    wire [7:0] p2_out_all;
    wire [7:0] p2_oe_all;

    // edge detect: rising when edge select clear, falling when set
    function [7:0] edge_hit;
        input [7:0] now;
        input [7:0] prev;
        input [7:0] ies;
        edge_hit = (~ies & now & ~prev) | (ies & ~now & prev);
    endfunction

    // input buffer gating and synchronisers
    assign p2_3_buffer_off = (supervisor_level_field == `PPM_LEVEL_OFF);
    assign p1_pad_in = port1_pin_in;
    assign p2_pad_in = {2'b00, port2_pin_in[5:4], port2_pin_in[3] & ~p2_3_buffer_off,
                        port2_pin_in[2:0]};

    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            p1_meta_q <= `PPM_RESET_BYTE;
            p1_sync_q <= `PPM_RESET_BYTE;
            p1_prev_q <= `PPM_RESET_BYTE;
            p2_meta_q <= `PPM_RESET_BYTE;
            p2_sync_q <= `PPM_RESET_BYTE;
            p2_prev_q <= `PPM_RESET_BYTE;
        end else begin
            p1_meta_q <= p1_pad_in;
            p1_sync_q <= p1_meta_q;
            p1_prev_q <= p1_sync_q;
            p2_meta_q <= p2_pad_in;
            p2_sync_q <= p2_meta_q;
            p2_prev_q <= p2_sync_q;
        end
    end

    assign port1_input = p1_sync_q;
    assign port2_input = p2_sync_q & `PPM_BONDED_P2;
    assign p1_edge = edge_hit(p1_sync_q, p1_prev_q, port1_edge_select_q);
    assign p2_edge = edge_hit(p2_sync_q, p2_prev_q, port2_edge_select_q) & `PPM_BONDED_P2;

    // module-side outputs per bit
    assign p1_mod_out = {serial_somi_out,
                         serial_simo_out,
                         aux_clock,
                         1'b0,
                         supervisor_output,
                         timer_out1,
                         2'b00};
    assign p1_mod_oe = {dir_ctrl_data_in_line,
                        dir_ctrl_data_out_line,
                        port1_direction_q[5:0]};
    assign p2_mod_out = {2'b00,
                         1'b0,
                         serial_transmit_data,
                         1'b0,
                         1'b0,
                         serial_clock_out,
                         timer_out2};
    assign p2_mod_oe = {port2_direction_q[7:6],
                        1'b0,
                        1'b1,
                        port2_direction_q[3],
                        1'b0,
                        dir_ctrl_serial_clock,
                        port2_direction_q[0]};

    // select clear: register output under direction bit
    assign port1_pin_out = (port1_function_select_q & p1_mod_out) |
                           (~port1_function_select_q & port1_output_q);
    assign port1_pin_oe = ((port1_function_select_q & p1_mod_oe) |
                           (~port1_function_select_q & port1_direction_q)) &
                          ~port1_lcd_mode;
    assign p2_out_all = (port2_function_select_q & p2_mod_out) |
                        (~port2_function_select_q & port2_output_q);
    assign p2_oe_all = (port2_function_select_q & p2_mod_oe) |
                       (~port2_function_select_q & port2_direction_q);
    assign port2_pin_out = p2_out_all[5:0];
    assign port2_pin_oe = p2_oe_all[5:0] & ~port2_lcd_mode;

    // lcd segment takeover
    assign port1_lcd_mode = {{2{lcd_port_range_field >= `PPM_LCD_P1_HIGH}},
                             {4{lcd_port_range_field >= `PPM_LCD_P1_LOW}},
                             2'b00};
    assign port2_lcd_mode = {4'h0, {2{lcd_port_range_field >= `PPM_LCD_P2_LOW}}};

    // module inputs taken from the synchronised pins
    assign timer_capture_in_1a = port1_input[2];
    assign timer_external_clock = port1_input[5];
    assign serial_slave_in_master_out = port1_input[6];
    assign serial_slave_out_master_in = port1_input[7];
    assign timer_capture_in_2a = port2_input[0];
    assign serial_clock_line = port2_input[1];
    assign serial_slave_strobe = port2_input[2];
    assign serial_receive_data = port2_input[5];

    assign port1_irq = |(port1_irq_flag_q & port1_irq_enable_q);
    assign port2_irq = |(port2_irq_flag_q & port2_irq_enable_q);

    // register writes; hardware edge set wins over software write
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            port1_output_q <= `PPM_RESET_BYTE;
            port1_direction_q <= `PPM_RESET_BYTE;
            port1_irq_flag_q <= `PPM_RESET_BYTE;
            port1_edge_select_q <= `PPM_RESET_BYTE;
            port1_irq_enable_q <= `PPM_RESET_BYTE;
            port1_function_select_q <= `PPM_RESET_BYTE;
            port2_output_q <= `PPM_RESET_BYTE;
            port2_direction_q <= `PPM_RESET_BYTE;
            port2_irq_flag_q <= `PPM_RESET_BYTE;
            port2_edge_select_q <= `PPM_RESET_BYTE;
            port2_irq_enable_q <= `PPM_RESET_BYTE;
            port2_function_select_q <= `PPM_RESET_BYTE;
        end else begin
            if (reg_write) begin
                case (reg_addr)
                    `PPM_ADDR_P1_OUT: port1_output_q <= reg_wdata;
                    `PPM_ADDR_P1_DIR: port1_direction_q <= reg_wdata;
                    `PPM_ADDR_P1_IES: port1_edge_select_q <= reg_wdata;
                    `PPM_ADDR_P1_IE: port1_irq_enable_q <= reg_wdata;
                    `PPM_ADDR_P1_SEL: port1_function_select_q <= reg_wdata;
                    `PPM_ADDR_P2_OUT: port2_output_q <= reg_wdata;
                    `PPM_ADDR_P2_DIR: port2_direction_q <= reg_wdata;
                    `PPM_ADDR_P2_IES: port2_edge_select_q <= reg_wdata;
                    `PPM_ADDR_P2_IE: port2_irq_enable_q <= reg_wdata;
                    `PPM_ADDR_P2_SEL: port2_function_select_q <= reg_wdata;
                    default: ;
                endcase
            end
            if (reg_write && reg_addr == `PPM_ADDR_P1_IFG)
                port1_irq_flag_q <= reg_wdata | p1_edge;
            else
                port1_irq_flag_q <= port1_irq_flag_q | p1_edge;
            if (reg_write && reg_addr == `PPM_ADDR_P2_IFG)
                port2_irq_flag_q <= reg_wdata | p2_edge;
            else
                port2_irq_flag_q <= port2_irq_flag_q | p2_edge;
        end
    end

    // read data one cycle after the strobe, zero otherwise
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= `PPM_RESET_BYTE;
        end else if (reg_read) begin
            case (reg_addr)
                `PPM_ADDR_P1_IN: reg_rdata <= port1_input;
                `PPM_ADDR_P1_OUT: reg_rdata <= port1_output_q;
                `PPM_ADDR_P1_DIR: reg_rdata <= port1_direction_q;
                `PPM_ADDR_P1_IFG: reg_rdata <= port1_irq_flag_q;
                `PPM_ADDR_P1_IES: reg_rdata <= port1_edge_select_q;
                `PPM_ADDR_P1_IE: reg_rdata <= port1_irq_enable_q;
                `PPM_ADDR_P1_SEL: reg_rdata <= port1_function_select_q;
                `PPM_ADDR_P2_IN: reg_rdata <= port2_input;
                `PPM_ADDR_P2_OUT: reg_rdata <= port2_output_q;
                `PPM_ADDR_P2_DIR: reg_rdata <= port2_direction_q;
                `PPM_ADDR_P2_IFG: reg_rdata <= port2_irq_flag_q;
                `PPM_ADDR_P2_IES: reg_rdata <= port2_edge_select_q;
                `PPM_ADDR_P2_IE: reg_rdata <= port2_irq_enable_q;
                `PPM_ADDR_P2_SEL: reg_rdata <= port2_function_select_q;
                default: reg_rdata <= `PPM_RESET_BYTE;
            endcase
        end else begin
            reg_rdata <= `PPM_RESET_BYTE;
        end
    end
endmodule

// file: logic/ppm_consts.vh
// constants for the port pin function multiplexer
// assumes inclusion by the single design module; definitions only
//
// Summary of operation
// - p1 bit2 select: drive timer compare 1, input feeds capture 1a, port direction.
// - p1 bit3 select: drive supervisor output, module input unused.
// - p1 bit4 select: module output is constant low, no module input.
// - p1 bit5 select: drive auxiliary clock, input feeds timer external clock.
// - p1 bit6 module mode: direction and data from serial slave-in/master-out line.
// - p1 bit7 module mode: direction and data from serial slave-out/master-in line.
// - p1 bits 2..5 port while lcd range below 05h, else segments 31..28.
// - p1 bits 6,7 port while lcd range below 04h, else segments 27,26.
// - p2 bit0 select: drive timer compare 2, input feeds capture 2a.
// - p2 bit1 module mode: direction and data from serial clock line.
// - p2 bits 0,1 port while lcd range below 04h, else segments 25,24.
// - p2 bit2 module mode: forced input, output low, input is slave strobe.
// - p2 bit3 input buffer off when supervisor level is 1111b; select drives low.
// - p2 bit4 module mode: forced output driving asynchronous transmit data.
// - p2 bit5 module mode: forced input, output low, input is receive data.
// - p2 bits 6,7 unbonded; flags change only by software writes.
`ifndef PPM_CONSTS_VH
`define PPM_CONSTS_VH
`define PPM_ADDR_P1_IN 4'h0
`define PPM_ADDR_P1_OUT 4'h1
`define PPM_ADDR_P1_DIR 4'h2
`define PPM_ADDR_P1_IFG 4'h3
`define PPM_ADDR_P1_IES 4'h4
`define PPM_ADDR_P1_IE 4'h5
`define PPM_ADDR_P1_SEL 4'h6
`define PPM_ADDR_P2_IN 4'h8
`define PPM_ADDR_P2_OUT 4'h9
`define PPM_ADDR_P2_DIR 4'ha
`define PPM_ADDR_P2_IFG 4'hb
`define PPM_ADDR_P2_IES 4'hc
`define PPM_ADDR_P2_IE 4'hd
`define PPM_ADDR_P2_SEL 4'he
`define PPM_RESET_BYTE 8'h00
`define PPM_LCD_P1_LOW 3'h5
`define PPM_LCD_P1_HIGH 3'h4
`define PPM_LCD_P2_LOW 3'h4
`define PPM_LEVEL_OFF 4'hf
`define PPM_BONDED_P2 8'h3f
`endif

// file: testbench/ppm_port_mux_asserts.sv
// checker for the port pin multiplexer, watching top-level ports only
// assumes core_clk rising edge and reset_n asynchronous active low
`timescale 1ns/1ps
module ppm_port_mux_asserts (
    input wire core_clk,
    input wire reset_n,
    input wire reg_read,
    input wire [7:0] reg_rdata,
    input wire [2:0] lcd_port_range_field,
    input wire [7:0] port1_pin_in,
    input wire [7:0] port1_pin_oe,
    input wire [7:0] port1_lcd_mode,
    input wire [5:0] port2_pin_in,
    input wire [5:0] port2_lcd_mode,
    input wire timer_capture_in_1a,
    input wire serial_receive_data,
    input wire serial_clock_line
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // two clean cycles out of reset before sync flops are trusted
    sequence settled;
        $past(reset_n) && $past(reset_n, 2);
    endsequence
    a_cap_sync: assert property (settled |-> timer_capture_in_1a == $past(port1_pin_in[2], 2))
        else $error("capture 1a not the synchronised pin");
    a_rx_sync: assert property (settled |-> serial_receive_data == $past(port2_pin_in[5], 2))
        else $error("receive data not the synchronised pin");
    a_clk_sync: assert property (settled |-> serial_clock_line == $past(port2_pin_in[1], 2))
        else $error("serial clock not the synchronised pin");
    a_lcd_p1_low: assert property (port1_lcd_mode[5:0] == {{4{lcd_port_range_field >= 3'h5}}, 2'h0})
        else $error("port1 low segment mode wrong");
    a_lcd_p1_high: assert property (port1_lcd_mode[7:6] == {2{lcd_port_range_field >= 3'h4}})
        else $error("port1 high segment mode wrong");
    a_lcd_p2_mode: assert property (port2_lcd_mode == {4'h0, {2{lcd_port_range_field >= 3'h4}}})
        else $error("port2 segment mode wrong");
    a_lcd_oe_off: assert property ((port1_lcd_mode & port1_pin_oe) == 8'h00)
        else $error("segment pin still driven");
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule
bind ppm_port_mux ppm_port_mux_asserts ppm_port_mux_asserts_i (.core_clk(core_clk),
    .reset_n(reset_n), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .lcd_port_range_field(lcd_port_range_field), .port1_pin_in(port1_pin_in),
    .port1_pin_oe(port1_pin_oe), .port1_lcd_mode(port1_lcd_mode), .port2_pin_in(port2_pin_in),
    .port2_lcd_mode(port2_lcd_mode), .timer_capture_in_1a(timer_capture_in_1a),
    .serial_receive_data(serial_receive_data), .serial_clock_line(serial_clock_line));

// file: testbench/ppm_board_model.sv
// board side of the pads: resolves each pin from mux drive and board drive
// assumes board drive only matters where the mux output enable is low
`timescale 1ns/1ps
module ppm_board_model (
    input wire [7:0] p1_out,
    input wire [7:0] p1_oe,
    input wire [7:0] p1_board,
    input wire [5:0] p2_out,
    input wire [5:0] p2_oe,
    input wire [5:0] p2_board,
    output wire [7:0] p1_pin,
    output wire [5:0] p2_pin
);
    assign p1_pin = (p1_oe & p1_out) | (~p1_oe & p1_board);
    assign p2_pin = (p2_oe & p2_out) | (~p2_oe & p2_board);
endmodule

// file: testbench/tb.sv
// register-level tests of the port pin multiplexer
// assumes the board model closes the pads
`timescale 1ns/1ps
module tb;
    logic core_clk = 0, reset_n = 0, wr_s = 0, rd_s = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, b1 = 8'h00;
    logic [5:0] b2 = 6'h00;
    logic [2:0] lcd = 3'h0;
    logic [3:0] lvl = 4'h0;
    logic [10:0] mods = 11'h000;
    wire [7:0] rdata, p1i, p1o, p1e, p1l;
    wire [5:0] p2i, p2o, p2e, p2l;
    wire [7:0] mi;
    wire q1, q2;
    int mismatches = 0, total_checks = 0;
    always #5 core_clk = ~core_clk;
    ppm_board_model ppm_board_model_i (.p1_out(p1o), .p1_oe(p1e), .p1_board(b1), .p2_out(p2o),
        .p2_oe(p2e), .p2_board(b2), .p1_pin(p1i), .p2_pin(p2i));
    ppm_port_mux ppm_port_mux_i (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(addr),
        .reg_wdata(wdata), .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata),
        .lcd_port_range_field(lcd), .supervisor_level_field(lvl), .port1_pin_in(p1i),
        .port1_pin_out(p1o), .port1_pin_oe(p1e), .port1_lcd_mode(p1l), .port2_pin_in(p2i),
        .port2_pin_out(p2o), .port2_pin_oe(p2e), .port2_lcd_mode(p2l), .timer_out1(mods[0]),
        .timer_out2(mods[1]), .supervisor_output(mods[2]), .aux_clock(mods[3]),
        .serial_simo_out(mods[4]), .serial_somi_out(mods[5]), .serial_clock_out(mods[6]),
        .serial_transmit_data(mods[7]), .dir_ctrl_data_out_line(mods[8]),
        .dir_ctrl_data_in_line(mods[9]), .dir_ctrl_serial_clock(mods[10]),
        .timer_capture_in_1a(mi[7]), .timer_external_clock(mi[6]),
        .serial_slave_in_master_out(mi[5]), .serial_slave_out_master_in(mi[4]),
        .timer_capture_in_2a(mi[3]), .serial_clock_line(mi[2]), .serial_slave_strobe(mi[1]),
        .serial_receive_data(mi[0]), .port1_irq(q1), .port2_irq(q2));
    task automatic finish_test;
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge core_clk);
        wr_s <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge core_clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge core_clk);
        rd_s <= 1'b0;
        #1 chk(rdata, e);
    endtask
    initial begin
        #500000 mismatches++;
        finish_test;
    end
    initial begin
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        #1 chk(p1e, 8'h00);
        rd(4'h6, 8'h00);
        wr(4'h7, 8'h5a);
        rd(4'h7, 8'h00);
        wr(4'h2, 8'hff);
        wr(4'h1, 8'ha5);
        chk(p1o, 8'ha5);
        mods <= 11'h11d;
        wr(4'h6, 8'hfc);
        chk(p1o, 8'h6d);
        chk(p1e, 8'h7f);
        mods <= 11'h220;
        #10 chk(p1o, 8'h81);
        chk(p1e, 8'hbf);
        mods <= 11'h4c2;
        wr(4'ha, 8'h3f);
        wr(4'he, 8'h3f);
        chk({2'h0, p2o}, 8'h13);
        chk({2'h0, p2e}, 8'h1b);
        mods <= 11'h040;
        #10 chk({2'h0, p2o}, 8'h02);
        chk({2'h0, p2e}, 8'h19);
        for (int r = 0; r < 8; r++) begin
            lcd <= r[2:0];
            #10 chk(p1l, {{2{r >= 4}}, {4{r >= 5}}, 2'h0});
            chk(p1e, 8'h3f & ~{{2{r >= 4}}, {4{r >= 5}}, 2'h0});
            chk({2'h0, p2e}, {2'h0, 6'h19 & ~{4'h0, {2{r >= 4}}}});
        end
        lcd <= 3'h0;
        wr(4'h6, 8'h00);
        wr(4'h2, 8'h00);
        wr(4'he, 8'h00);
        wr(4'ha, 8'h00);
        b1 <= 8'h64;
        b2 <= 6'h26;
        #40 chk(mi, 8'he7);
        rd(4'h0, 8'h64);
        rd(4'h8, 8'h26);
        b2 <= 6'h08;
        lvl <= 4'hf;
        #40 rd(4'h8, 8'h00);
        lvl <= 4'h0;
        #40 rd(4'h8, 8'h08);
        wr(4'h3, 8'h00);
        wr(4'h5, 8'h01);
        b1 <= 8'h65;
        #40 rd(4'h3, 8'h01);
        chk({7'h0, q1}, 8'h01);
        wr(4'h4, 8'h01);
        wr(4'h3, 8'h00);
        chk({7'h0, q1}, 8'h00);
        b1 <= 8'h64;
        #40 rd(4'h3, 8'h01);
        wr(4'hb, 8'hc0);
        wr(4'hd, 8'hc0);
        chk({7'h0, q2}, 8'h01);
        rd(4'hb, 8'hc0);
        finish_test;
    end
endmodule
